// ==== rtl/kmb_keypad.sv ====
/*
  Keypad front end: event-driven 5x5 matrix scan, debounce, key coding,
  auto-repeat, ten-entry buffer, command decoding and read answers.
  Assumes a byte-level serial receiver and transmitter outside, and a
  two-wire bus slave outside that raises bus_rd when the module is read
  at base address plus one and takes bus_data the cycle after that request.
*/
`timescale 1ns/1ps
`default_nettype none
module kmb_keypad #(
  parameter int unsigned DEB_STEP = kmb_pkg::DEB_STEP_CYC,
  parameter int unsigned RPT_DELAY = kmb_pkg::RPT_DELAY_CYC,
  parameter int unsigned RPT_RATE = kmb_pkg::RPT_RATE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] row_in,
  output logic [4:0] col_drive,
  input wire kmb_pkg::kmb_byte_t rx,
  output kmb_pkg::kmb_byte_t tx,
  input wire logic tx_ready,
  input wire logic bus_sel,
  input wire logic bus_rd,
  output logic [7:0] bus_data,
  output logic polled_mode,
  output logic [3:0] key_count
);
  import kmb_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_DEB, S_SCAN, S_HELD, S_REL} kmb_scan_t;
  typedef enum logic [1:0] {C_IDLE, C_PFX, C_RPT, C_DEB} kmb_cmd_t;

  // ---------------------------------------------------------------
  // Row input synchroniser
  // ---------------------------------------------------------------
  logic [4:0] row_s1_r;
  logic [4:0] row_s2_r;
  logic [4:0] row_s3_r;
  logic [4:0] row_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      row_s1_r <= 5'h0;
      row_s2_r <= 5'h0;
      row_s3_r <= 5'h0;
      row_r <= 5'h0;
    end else begin
      row_s1_r <= row_in;
      row_s2_r <= row_s1_r;
      row_s3_r <= row_s2_r;
      if (row_s2_r == row_s3_r) begin
        row_r <= row_s3_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // Command decoder and mode state
  // ---------------------------------------------------------------
  kmb_cmd_t cst_r;
  kmb_rpt_t rpt_r;
  logic auto_r;
  logic [7:0] deb_units_r;
  logic clr_cmd;
  logic poll_cmd;

  wire rxv = rx.valid;
  wire [7:0] rxd = rx.data;
  assign clr_cmd = rxv && (cst_r == C_PFX) && (rxd == CMD_CLEAR);
  assign poll_cmd = rxv && (cst_r == C_PFX) && (rxd == CMD_POLL);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cst_r <= C_IDLE;
      rpt_r <= KMB_RPT_OFF;
      auto_r <= 1'b1;
      deb_units_r <= DEB_RESET_UNITS;
    end else if (rxv) begin
      case (cst_r)
        C_IDLE: begin
          cst_r <= (rxd == CMD_PREFIX) ? C_PFX : C_IDLE;
        end
        C_PFX: begin
          cst_r <= C_IDLE;
          if (rxd == CMD_RPT_ON) begin
            cst_r <= C_RPT;
          end else if (rxd == CMD_RPT_OFF) begin
            rpt_r <= KMB_RPT_OFF;
          end else if (rxd == CMD_AUTO_ON) begin
            auto_r <= 1'b1;
          end else if (rxd == CMD_AUTO_OFF) begin
            auto_r <= 1'b0;
          end else if (rxd == CMD_DEBOUNCE) begin
            cst_r <= C_DEB;
          end else if (rxd == CMD_PREFIX) begin
            cst_r <= C_PFX;
          end
        end
        C_RPT: begin
          cst_r <= C_IDLE;
          rpt_r <= (rxd == 8'h00) ? KMB_RPT_RESEND : KMB_RPT_UPDOWN;
        end
        default: begin
          cst_r <= C_IDLE;
          deb_units_r <= rxd;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Scan, debounce and key events
  // ---------------------------------------------------------------
  kmb_scan_t sst_r;
  logic [31:0] tmr_r;
  logic [2:0] col_r;
  logic [2:0] hit_row_r;
  logic [2:0] hit_col_r;
  logic [4:0] col_drive_r;
  logic ev_r;
  logic [7:0] ev_code_r;
  logic rpt_phase_r;

  wire any_row = |row_r;
  wire [31:0] deb_cycles = 32'(deb_units_r) * 32'(DEB_STEP);

  function automatic logic [2:0] first_row(input logic [4:0] r);
    logic [2:0] i;
    i = 3'h0;
    for (int k = 4; k >= 0; k--) begin
      if (r[k]) begin
        i = 3'(k);
      end
    end
    return i;
  endfunction

  // Row-major key code
  wire [7:0] key_code = KEY_FIRST + 8'(hit_row_r) * 8'(COLS) + 8'(hit_col_r);
  wire held_key = row_r[hit_row_r];
  wire settled = (tmr_r == 32'(SCAN_SETTLE_CYC));
  wire resend_ok = (rpt_r == KMB_RPT_RESEND) && auto_r;
  // Press/release codes apply in up/down mode, and under resend when polled
  wire updown = (rpt_r == KMB_RPT_UPDOWN) || ((rpt_r == KMB_RPT_RESEND) && !auto_r);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sst_r <= S_IDLE;
      tmr_r <= 32'h0;
      col_r <= 3'h0;
      hit_row_r <= 3'h0;
      hit_col_r <= 3'h0;
      col_drive_r <= 5'h1f;
      ev_r <= 1'b0;
      ev_code_r <= 8'h00;
      rpt_phase_r <= 1'b0;
    end else begin
      ev_r <= 1'b0;
      tmr_r <= tmr_r + 32'h1;
      case (sst_r)
        S_IDLE: begin
          col_drive_r <= 5'h1f;
          tmr_r <= 32'h0;
          if (any_row) begin
            sst_r <= S_DEB;
          end
        end
        S_DEB: begin
          if (!any_row) begin
            sst_r <= S_IDLE;
          end else if (tmr_r >= deb_cycles) begin
            sst_r <= S_SCAN;
            col_r <= 3'h0;
            col_drive_r <= 5'h01;
            tmr_r <= 32'h0;
          end
        end
        S_SCAN: begin
          if (settled) begin
            tmr_r <= 32'h0;
            if (any_row) begin
              hit_row_r <= first_row(row_r);
              hit_col_r <= col_r;
              col_drive_r <= 5'(5'h01 << col_r);
              sst_r <= S_HELD;
              rpt_phase_r <= 1'b0;
              ev_r <= 1'b1;
              ev_code_r <= KEY_FIRST + 8'(first_row(row_r)) * 8'(COLS) + 8'(col_r);
            end else if (col_r == 3'(COLS - 1)) begin
              sst_r <= S_IDLE;
            end else begin
              col_r <= col_r + 3'h1;
              col_drive_r <= 5'(col_drive_r << 1);
            end
          end
        end
        S_HELD: begin
          if (!held_key) begin
            sst_r <= S_REL;
            tmr_r <= 32'h0;
            if (updown) begin
              ev_r <= 1'b1;
              ev_code_r <= key_code + RELEASE_OFS;
            end
          end else if (resend_ok) begin
            if (tmr_r >= (rpt_phase_r ? 32'(RPT_RATE) : 32'(RPT_DELAY))) begin
              tmr_r <= 32'h0;
              rpt_phase_r <= 1'b1;
              ev_r <= 1'b1;
              ev_code_r <= key_code;
            end
          end
        end
        default: begin
          col_drive_r <= 5'h1f;
          if (any_row) begin
            tmr_r <= 32'h0;
          end else if (tmr_r >= deb_cycles) begin
            sst_r <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Key buffer
  // ---------------------------------------------------------------
  logic [7:0] head;
  logic [3:0] cnt;
  logic fifo_rd;

  kmb_key_fifo #(.DEPTH(BUF_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .clr(clr_cmd),
    .wr(ev_r && !auto_r),
    .wr_data(ev_code_r),
    .rd(fifo_rd),
    .head(head),
    .count(cnt)
  );

  // Oldest code with more-flag, or zero when empty
  function automatic logic [7:0] answer(input logic [7:0] h, input logic [3:0] c);
    logic [7:0] a;
    a = (c == 4'h0) ? EMPTY_CODE : {1'b0, h[6:0]};
    a[MORE_BIT] = (c > 4'h1);
    return a;
  endfunction

  wire bus_take = bus_sel && bus_rd;
  wire [7:0] ans = answer(head, cnt);
  assign fifo_rd = bus_take || poll_cmd;

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  logic tx_pend_r;
  logic [7:0] tx_d_r;
  logic [7:0] bus_data_r;
  logic polled_r;
  logic [3:0] cnt_out_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_pend_r <= 1'b0;
      tx_d_r <= 8'h00;
      bus_data_r <= 8'h00;
      polled_r <= 1'b0;
      cnt_out_r <= 4'h0;
    end else begin
      polled_r <= !auto_r;
      cnt_out_r <= cnt;
      if (bus_take) begin
        bus_data_r <= ans;
      end
      if (poll_cmd) begin
        tx_pend_r <= 1'b1;
        tx_d_r <= ans;
      end else if (ev_r && auto_r) begin
        tx_pend_r <= 1'b1;
        tx_d_r <= ev_code_r;
      end else if (tx_ready) begin
        tx_pend_r <= 1'b0;
      end
    end
  end

  assign tx.valid = tx_pend_r;
  assign tx.data = tx_d_r;
  assign bus_data = bus_data_r;
  assign col_drive = col_drive_r;
  assign polled_mode = polled_r;
  assign key_count = cnt_out_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_empty_zero: assert property (@(posedge core_clk) disable iff (rst)
    bus_take && (cnt == 4'h0) |=> bus_data == 8'h00)
    else $error("empty read not zero");
  a_more_bit: assert property (@(posedge core_clk) disable iff (rst)
    bus_take && (cnt > 4'h1) |=> bus_data[7])
    else $error("more flag missing");
  a_last_bit: assert property (@(posedge core_clk) disable iff (rst)
    bus_take && (cnt == 4'h1) |=> !bus_data[7])
    else $error("last code has more flag");
  a_no_scan: assert property (@(posedge core_clk) disable iff (rst)
    (sst_r == S_IDLE) && !any_row |=> sst_r != S_SCAN)
    else $error("scan without press");
  a_auto_send: assert property (@(posedge core_clk) disable iff (rst)
    ev_r && auto_r && !poll_cmd |=> tx_pend_r && (tx_d_r == $past(ev_code_r)))
    else $error("key code not sent");
  a_poll_send: assert property (@(posedge core_clk) disable iff (rst)
    poll_cmd |=> tx_pend_r)
    else $error("poll answer not sent");
  a_clear_buf: assert property (@(posedge core_clk) disable iff (rst)
    clr_cmd |=> cnt == 4'h0)
    else $error("clear left entries");
  a_no_resend: assert property (@(posedge core_clk) disable iff (rst)
    (sst_r == S_HELD) && held_key && !auto_r |=> !ev_r)
    else $error("repeat while polled");
  a_rel_code: assert property (@(posedge core_clk) disable iff (rst)
    (sst_r == S_HELD) && !held_key && updown |=> ev_r && (ev_code_r == $past(key_code) + 8'h20))
    else $error("bad release code");
endmodule
`default_nettype wire

// ==== rtl/kmb_pkg.sv ====
/*
  Shared constants and carrier types for the keypad matrix key buffer.
  Assumes a 100 MHz core clock; the debounce and repeat counts derive from it.
*/
package kmb_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned DEB_STEP_US = 6554;
  localparam int unsigned DEB_STEP_CYC = DEB_STEP_US * CLK_MHZ;
  localparam int unsigned RPT_DELAY_MS = 500;
  localparam int unsigned RPT_DELAY_CYC = RPT_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned RPT_RATE_MS = 200;
  localparam int unsigned RPT_RATE_CYC = RPT_RATE_MS * 1000 * CLK_MHZ;
  localparam int unsigned SCAN_SETTLE_CYC = 4;
  localparam logic [7:0] DEB_RESET_UNITS = 8'h08;

  // ---------------------------------------------------------------
  // Matrix and buffer
  // ---------------------------------------------------------------
  localparam int unsigned ROWS = 5;
  localparam int unsigned COLS = 5;
  localparam int unsigned BUF_DEPTH = 10;
  localparam logic [7:0] KEY_FIRST = 8'h41;
  localparam logic [7:0] RELEASE_OFS = 8'h20;
  localparam logic [7:0] EMPTY_CODE = 8'h00;
  localparam int unsigned MORE_BIT = 7;

  // ---------------------------------------------------------------
  // Command bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_PREFIX = 8'hfe;
  localparam logic [7:0] CMD_RPT_ON = 8'h7e;
  localparam logic [7:0] CMD_RPT_OFF = 8'h60;
  localparam logic [7:0] CMD_AUTO_ON = 8'h41;
  localparam logic [7:0] CMD_AUTO_OFF = 8'h4f;
  localparam logic [7:0] CMD_CLEAR = 8'h45;
  localparam logic [7:0] CMD_POLL = 8'h26;
  localparam logic [7:0] CMD_DEBOUNCE = 8'h55;

  typedef enum logic [1:0] {KMB_RPT_OFF, KMB_RPT_RESEND, KMB_RPT_UPDOWN} kmb_rpt_t;

  // Byte with strobe
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } kmb_byte_t;

endpackage

// ==== rtl/kmb_key_fifo.sv ====
/*
  Ten-entry key code buffer with drop-when-full and clear.
  Assumes one core clock; write and read strobes are single-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module kmb_key_fifo #(
  parameter int unsigned DEPTH = kmb_pkg::BUF_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic wr,
  input wire logic [7:0] wr_data,
  input wire logic rd,
  output logic [7:0] head,
  output logic [3:0] count
);
  import kmb_pkg::*;

  logic [7:0] mem [DEPTH];
  logic [3:0] wp_r;
  logic [3:0] rp_r;
  logic [3:0] cnt_r;
  wire do_wr = wr && (cnt_r != 4'(DEPTH));
  wire do_rd = rd && (cnt_r != 4'h0);

  function automatic logic [3:0] bump(input logic [3:0] p);
    return (p == 4'(DEPTH - 1)) ? 4'h0 : p + 4'h1;
  endfunction

  assign head = mem[rp_r];
  assign count = cnt_r;

  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wp_r] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wp_r <= 4'h0;
      rp_r <= 4'h0;
      cnt_r <= 4'h0;
    end else if (clr) begin
      wp_r <= 4'h0;
      rp_r <= 4'h0;
      cnt_r <= 4'h0;
    end else begin
      if (do_wr) begin
        wp_r <= bump(wp_r);
      end
      if (do_rd) begin
        rp_r <= bump(rp_r);
      end
      cnt_r <= cnt_r + {3'h0, do_wr} - {3'h0, do_rd};
    end
  end

  a_full_drop: assert property (@(posedge core_clk) disable iff (rst)
    (cnt_r == 4'(DEPTH)) && !rd && !clr |=> cnt_r == 4'(DEPTH))
    else $error("full buffer changed count without read");
endmodule
`default_nettype wire

// ==== bench/kmb_keypad_model.sv ====
/*
  Keypad matrix model: one key at a time joins its column to its row.
  Assumes key index 0..24 in row-major order and driven columns high.
*/
`timescale 1ns/1ps
`default_nettype none
module kmb_keypad_model (
  input wire logic key_dn,
  input wire logic [4:0] key_idx,
  input wire logic [4:0] col_drive,
  output logic [4:0] row_in
);
  logic [2:0] row_sel;
  logic [2:0] col_sel;
  assign row_sel = 3'(key_idx / 5'd5);
  assign col_sel = 3'(key_idx % 5'd5);
  // Contact conducts only while its column is driven
  assign row_in = (key_dn && col_drive[col_sel]) ? (5'h01 << row_sel) : 5'h00;
endmodule
`default_nettype wire

// ==== bench/kmb_keypad_bench.sv ====
/*
  Self-checking bench for the keypad key buffer: commands, keys, bus reads.
  Assumes scaled timing parameters and a host that always accepts tx bytes.
*/
`timescale 1ns/1ps
`default_nettype none
module kmb_keypad_bench;
  import kmb_pkg::*;
  logic core_clk, rst, tx_ready, bus_sel, bus_rd, polled_mode, key_dn;
  logic [4:0] row_in, col_drive, key_idx;
  logic [7:0] bus_data;
  logic [3:0] key_count;
  kmb_byte_t rx, tx;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int k;
  int exp_q[$];
  logic [7:0] tx_q[$];
  logic [31:0] seed;

  kmb_keypad #(.DEB_STEP(10), .RPT_DELAY(200), .RPT_RATE(80)) i_kmb_keypad (
    .core_clk(core_clk), .rst(rst), .row_in(row_in), .col_drive(col_drive),
    .rx(rx), .tx(tx), .tx_ready(tx_ready), .bus_sel(bus_sel), .bus_rd(bus_rd),
    .bus_data(bus_data), .polled_mode(polled_mode), .key_count(key_count));
  kmb_keypad_model i_kmb_keypad_model (
    .key_dn(key_dn), .key_idx(key_idx), .col_drive(col_drive), .row_in(row_in));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Transmit capture and timeout
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (!rst && tx.valid === 1'b1 && tx_ready) tx_q.push_back(tx.data);
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [7:0] next_exp();
    logic [7:0] e;
    e = EMPTY_CODE;
    if (exp_q.size() > 0) e = 8'(exp_q.pop_front());
    if (exp_q.size() > 0) e[MORE_BIT] = 1'b1;
    return e;
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic send(input logic [7:0] b);
    rx = '{valid: 1'b1, data: b};
    tick(1);
  endtask

  task automatic cmd(input logic [7:0] c, input int np, input logic [7:0] p);
    send(CMD_PREFIX);
    send(c);
    if (np > 0) send(p);
    rx.valid = 1'b0;
    tick(2);
  endtask

  task automatic key(input int kk, input int hold);
    key_idx = 5'(kk);
    key_dn = 1'b1;
    tick(hold);
    key_dn = 1'b0;
    tick(150);
  endtask

  task automatic wait_tx(input logic [7:0] exp);
    int n;
    n = 0;
    while (tx_q.size() == 0 && n < 400) begin
      tick(1);
      n++;
    end
    chk_byte((tx_q.size() > 0) ? tx_q.pop_front() : ~exp, exp);
  endtask

  // Press and time the first code; key stays held
  task automatic press_wait(input int kk, input int lo, input int hi);
    int lat;
    lat = 0;
    key_idx = 5'(kk);
    key_dn = 1'b1;
    while (tx_q.size() == 0 && lat < 400) begin
      tick(1);
      lat++;
    end
    chk_flag(lat >= lo && lat <= hi, 1'b1);
    wait_tx(KEY_FIRST + 8'(kk));
  endtask

  task automatic bus_read();
    logic [7:0] e;
    e = next_exp();
    bus_sel = 1'b1;
    bus_rd = 1'b1;
    tick(1);
    bus_rd = 1'b0;
    bus_sel = 1'b0;
    chk_byte(bus_data, e);
    tick(1);
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h5db1;
    rst = 1'b1;
    rx = '0;
    tx_ready = 1'b1;
    bus_sel = 1'b0;
    bus_rd = 1'b0;
    key_dn = 1'b0;
    key_idx = 5'h00;
    tick(16);
    rst = 1'b0;
    chk_byte({3'h0, tx.valid, key_count}, 8'h00);
    chk_flag(polled_mode, 1'b0);
    tick(50);
    chk_byte({3'h0, col_drive}, 8'h1f);
    press_wait(int'(rnd() % 25), 80, 140);
    key_dn = 1'b0;
    tick(150);
    cmd(CMD_DEBOUNCE, 1, 8'h02);
    press_wait(int'(rnd() % 25), 20, 60);
    key_dn = 1'b0;
    tick(150);
    for (k = 0; k < 25; k++) begin
      key(k, 80);
      wait_tx(KEY_FIRST + 8'(k));
    end
    cmd(CMD_RPT_ON, 1, 8'h01);
    k = int'(rnd() % 25);
    key(k, 300);
    wait_tx(KEY_FIRST + 8'(k));
    wait_tx(KEY_FIRST + 8'(k) + RELEASE_OFS);
    cmd(CMD_RPT_ON, 1, 8'h00);
    press_wait(k, 20, 60);
    tick(400);
    key_dn = 1'b0;
    tick(150);
    chk_byte(8'(tx_q.size()), 8'h03);
    while (tx_q.size() > 0) chk_byte(tx_q.pop_front(), KEY_FIRST + 8'(k));
    cmd(CMD_RPT_OFF, 0, 8'h00);
    key(k, 300);
    chk_byte(8'(tx_q.size()), 8'h01);
    tx_q.delete();
    cmd(CMD_AUTO_OFF, 0, 8'h00);
    chk_flag(polled_mode, 1'b1);
    for (int i = 0; i < 11; i++) begin
      k = int'(rnd() % 25);
      key(k, 80);
      if (exp_q.size() < 10) exp_q.push_back(int'(KEY_FIRST) + k);
    end
    chk_byte({4'h0, key_count}, 8'h0a);
    chk_byte(8'(tx_q.size()), 8'h00);
    cmd(CMD_POLL, 0, 8'h00);
    wait_tx(next_exp());
    for (int i = 0; i < 10; i++) bus_read();
    cmd(CMD_POLL, 0, 8'h00);
    wait_tx(EMPTY_CODE);
    key(3, 80);
    key(7, 80);
    cmd(CMD_CLEAR, 0, 8'h00);
    tick(2);
    chk_byte({4'h0, key_count}, 8'h00);
    bus_read();
    cmd(CMD_RPT_ON, 1, 8'h00);
    k = int'(rnd() % 25);
    key(k, 500);
    exp_q.push_back(int'(KEY_FIRST) + k);
    exp_q.push_back(int'(KEY_FIRST + RELEASE_OFS) + k);
    chk_byte({4'h0, key_count}, 8'h02);
    bus_read();
    bus_read();
    cmd(CMD_AUTO_ON, 0, 8'h00);
    chk_flag(polled_mode, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
